// file: logic/spc_parallel_clocking.v
// Parallel-side transmit and receive clocking with phase-align buffer and Wishbone registers
//
// Summary of operation
// - Reference clock times the transmit character clock
// - Reference clock may capture transmit data instead
// - Select zero: input clock captures transmit characters
// - Buffer absorbs half-cycle drift after initialisation
// - Buffer overflow or underflow raises sticky error
// - Writing recenter bit as zero initialises buffer
// - Error clears only once buffer is initialised
// - Output clock at one or two times reference
// - Output clock derived from measured reference clock period
// - Half-rate mode samples on both reference edges
// - Half-rate mode updates error on both edges
// - Full rate: data changes on true rising edge
// - Half rate: data changes on both clock edges
// - Self-test status shown on low data bits
// - Status bit valid only in self-test mode 10
// - Receive clock is driven by received characters at chosen rate and stops when none arrive
//
// Decided for this implementation: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`include "spc_map.vh"

module spc_parallel_clocking
(
    input  wire        i_core_clk,
    input  wire        i_resetn,
    input  wire        i_wb_cyc,
    input  wire        i_wb_stb,
    input  wire        i_wb_we,
    input  wire [7:0]  i_wb_adr,
    input  wire [3:0]  i_wb_sel,
    input  wire [31:0] i_wb_dat,
    output reg  [31:0] o_wb_dat,
    output reg         o_wb_ack,
    output reg         o_irq,
    input  wire        i_ref_clock,
    input  wire        i_tx_input_clock,
    input  wire [9:0]  i_tx_parallel_data,
    output reg  [9:0]  o_tx_char,
    output reg         o_tx_char_valid,
    output reg         o_tx_clock_out,
    output reg         o_tx_path_error,
    input  wire        i_rx_char_valid,
    input  wire [9:0]  i_rx_char,
    input  wire [2:0]  i_rx_bist_status,
    output reg  [9:0]  o_rx_parallel_data,
    output reg         o_rx_clock_out,
    output reg         o_rx_clock_out_n,
    output reg         o_bist_status_bit
);

    function [7:0] spc_frac;
        input [7:0] period;
        input [1:0] shift;
        begin
            spc_frac = period >> shift;
        end
    endfunction

    function [7:0] spc_count_up;
        input [7:0] cnt;
        begin
            spc_count_up = (cnt == `SPC_CNT_MAX) ? cnt : cnt + 8'h01;
        end
    endfunction

    // Two-bit wrap is the buffer ring; the carry is dropped on purpose
    function [1:0] spc_ptr_add;
        input [1:0] ptr;
        input [1:0] step;
        begin
            spc_ptr_add = ptr + step;
        end
    endfunction

    // Pin synchronisers; stage one feeds stage two only
    reg        ref_s1;
    reg        ref_s2;
    reg        ref_d;
    reg        txc_s1;
    reg        txc_s2;
    reg        txc_d;
    reg [9:0]  txd_s1;
    reg [9:0]  txd_s2;

    always @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            ref_s1 <= 1'b0;
            ref_s2 <= 1'b0;
            ref_d  <= 1'b0;
            txc_s1 <= 1'b0;
            txc_s2 <= 1'b0;
            txc_d  <= 1'b0;
        end
        else
        begin
            ref_s1 <= i_ref_clock;
            ref_s2 <= ref_s1;
            ref_d  <= ref_s2;
            txc_s1 <= i_tx_input_clock;
            txc_s2 <= txc_s1;
            txc_d  <= txc_s2;
        end
    end

    // Data pins share the clock pins' two-stage delay so capture lines up
    always @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            txd_s1 <= 10'h000;
            txd_s2 <= 10'h000;
        end
        else
        begin
            txd_s1 <= i_tx_parallel_data;
            txd_s2 <= txd_s1;
        end
    end

    // Control register fields
    reg [6:0]  ctrl;
    reg [2:0]  irq_status;
    reg [2:0]  irq_enable;
    wire       tx_clock_select  = ctrl[`SPC_CTRL_TX_CLK_SEL];
    wire       tx_rate_select   = ctrl[`SPC_CTRL_TX_RATE];
    wire       tx_half_rate     = ctrl[`SPC_CTRL_TX_HALF];
    wire       rx_rate_select   = ctrl[`SPC_CTRL_RX_RATE];
    wire [1:0] rx_selftest_mode = ctrl[`SPC_CTRL_RX_BIST_HI:`SPC_CTRL_RX_BIST_LO];

    wire ref_rise = ref_s2 & ~ref_d;
    wire ref_fall = ~ref_s2 & ref_d;
    wire txc_rise = txc_s2 & ~txc_d;
    wire char_strobe = ref_rise | (tx_half_rate & ref_fall);

    // Bus decode
    // Ack gate stops a held request from being taken twice
    wire bus_req  = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    wire bus_wr   = bus_req & i_wb_we;
    wire wr_ctrl  = bus_wr & (i_wb_adr == `SPC_ADDR_CTRL) & i_wb_sel[0];
    wire wr_clear = bus_wr & (i_wb_adr == `SPC_ADDR_IRQ_CLEAR) & i_wb_sel[0];
    wire wr_en    = bus_wr & (i_wb_adr == `SPC_ADDR_IRQ_ENABLE) & i_wb_sel[0];
    wire recenter = wr_ctrl & ~i_wb_dat[`SPC_CTRL_RECENTER];

    // Phase-align buffer, depth four, started half full
    reg [9:0]  buf_mem [0:3];
    reg [1:0]  wr_ptr;
    reg [1:0]  rd_ptr;
    reg [2:0]  level;
    reg        path_error;

    wire buf_wr    = ~tx_clock_select & txc_rise;
    wire buf_rd    = ~tx_clock_select & char_strobe;
    wire overflow  = buf_wr & ~buf_rd & (level == `SPC_BUF_DEPTH);
    wire underflow = buf_rd & ~buf_wr & (level == 3'h0);
    wire do_wr     = buf_wr & ~overflow;
    wire do_rd     = buf_rd & ~underflow;

    always @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            wr_ptr     <= 2'h2;
            rd_ptr     <= 2'h0;
            level      <= `SPC_BUF_CENTER;
            path_error <= 1'b0;
            buf_mem[0] <= 10'h000;
            buf_mem[1] <= 10'h000;
            buf_mem[2] <= 10'h000;
            buf_mem[3] <= 10'h000;
        end
        else if (recenter)
        begin
            // Two slots of slack each way give the half-cycle drift margin
            wr_ptr     <= spc_ptr_add(rd_ptr, 2'h2);
            level      <= `SPC_BUF_CENTER;
            path_error <= overflow | underflow;
        end
        else
        begin
            if (do_wr)
            begin
                buf_mem[wr_ptr] <= txd_s2;
                wr_ptr          <= spc_ptr_add(wr_ptr, 2'h1);
            end
            if (do_rd)
                rd_ptr <= spc_ptr_add(rd_ptr, 2'h1);
            case ({do_wr, do_rd})
                2'b10:   level <= level + 3'h1;
                2'b01:   level <= level - 3'h1;
                default: level <= level;
            endcase
            if (overflow | underflow)
                path_error <= 1'b1;
        end
    end

    // Character out to the serializer, timed by the reference clock
    always @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_tx_char       <= 10'h000;
            o_tx_char_valid <= 1'b0;
            o_tx_path_error <= 1'b0;
        end
        else
        begin
            o_tx_char_valid <= char_strobe;
            if (char_strobe)
            begin
                if (tx_clock_select)
                    o_tx_char <= txd_s2;
                // Underflow repeats the last character instead of a stale slot
                else if (level != 3'h0)
                    o_tx_char <= buf_mem[rd_ptr];
                o_tx_path_error <= path_error;
            end
        end
    end

    // Transmit output clock from the measured reference clock period
    reg [7:0] ref_cnt;
    reg [7:0] ref_period;
    reg       next_tx_clk;
    wire [7:0] ref_half    = spc_frac(ref_period, 2'h1);
    wire [7:0] ref_quarter = spc_frac(ref_period, 2'h2);

    // Restarts on each reference rise, so it tracks the pin's phase as well as its period
    always @*
    begin
        if (tx_rate_select)
            next_tx_clk = (ref_cnt < ref_quarter) |
                          ((ref_cnt >= ref_half) &
                           ({1'b0, ref_cnt} < {1'b0, ref_half} + {1'b0, ref_quarter}));
        else
            next_tx_clk = ref_cnt < ref_half;
    end

    always @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            ref_cnt        <= 8'h00;
            ref_period     <= 8'h02;
            o_tx_clock_out <= 1'b0;
        end
        else
        begin
            if (ref_rise)
            begin
                ref_period <= spc_count_up(ref_cnt);
                ref_cnt    <= 8'h00;
            end
            else
                ref_cnt <= spc_count_up(ref_cnt);
            o_tx_clock_out <= next_tx_clk;
        end
    end

    // Receive output clock and data
    reg [7:0] rx_cnt;
    reg [7:0] rx_period;
    reg       next_rx_clk;
    reg [9:0] next_rx_data;
    reg       next_bist_bit;

    always @*
    begin
        if (rx_rate_select)
            next_rx_clk = i_rx_char_valid ? ~o_rx_clock_out : o_rx_clock_out;
        else
            // Nine bits keep a saturated count from wrapping the clock high
            next_rx_clk = i_rx_char_valid |
                          ({1'b0, rx_cnt} + 9'h001 < {1'b0, spc_frac(rx_period, 2'h1)});
        next_bist_bit = (rx_selftest_mode == `SPC_BIST_REPORT) & i_rx_bist_status[2];
        if (rx_selftest_mode != 2'h0)
            next_rx_data = {8'h00, i_rx_bist_status[1:0]};
        else
            next_rx_data = i_rx_char;
    end

    always @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            rx_cnt             <= 8'h00;
            rx_period          <= 8'h02;
            o_rx_clock_out     <= 1'b0;
            o_rx_clock_out_n   <= 1'b1;
            o_rx_parallel_data <= 10'h000;
            o_bist_status_bit  <= 1'b0;
        end
        else
        begin
            if (i_rx_char_valid)
            begin
                rx_period          <= spc_count_up(rx_cnt);
                rx_cnt             <= 8'h00;
                o_rx_parallel_data <= next_rx_data;
                o_bist_status_bit  <= next_bist_bit;
            end
            else
                rx_cnt <= spc_count_up(rx_cnt);
            o_rx_clock_out   <= next_rx_clk;
            o_rx_clock_out_n <= ~next_rx_clk;
        end
    end

    // Registers, sticky events and interrupt
    wire [2:0] events;
    assign events[`SPC_IRQ_OVERFLOW]   = overflow;
    assign events[`SPC_IRQ_UNDERFLOW]  = underflow;
    assign events[`SPC_IRQ_RECENTERED] = recenter;

    reg [31:0] next_rd;

    always @*
    begin
        case (i_wb_adr)
            `SPC_ADDR_CTRL:       next_rd = {25'h0, ctrl};
            `SPC_ADDR_STATUS:     next_rd = {28'h0000000, level, path_error};
            `SPC_ADDR_IRQ_STATUS: next_rd = {29'h0, irq_status};
            `SPC_ADDR_IRQ_ENABLE: next_rd = {29'h0, irq_enable};
            default:              next_rd = 32'h00000000;
        endcase
    end

    always @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            ctrl       <= `SPC_CTRL_RESET;
            irq_enable <= 3'h0;
            o_wb_ack   <= 1'b0;
            o_wb_dat   <= 32'h00000000;
        end
        else
        begin
            o_wb_ack <= bus_req;
            if (bus_req & ~i_wb_we)
                o_wb_dat <= next_rd;
            if (wr_ctrl)
                ctrl <= i_wb_dat[6:0];
            if (wr_en)
                irq_enable <= i_wb_dat[2:0];
        end
    end

    // Sticky events and level interrupt, one cycle behind status
    always @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            irq_status <= 3'h0;
            o_irq      <= 1'b0;
        end
        else
        begin
            // A new event wins over a clear in the same cycle
            irq_status <= (irq_status & ~(wr_clear ? i_wb_dat[2:0] : 3'h0)) | events;
            o_irq      <= |(irq_status & irq_enable);
        end
    end

endmodule

// file: logic/spc_map.vh
// Register offsets, field positions, reset values and sizes of the parallel clocking block
`ifndef SPC_MAP_VH
`define SPC_MAP_VH

`define SPC_ADDR_CTRL        8'h00
`define SPC_ADDR_STATUS      8'h04
`define SPC_ADDR_IRQ_STATUS  8'h08
`define SPC_ADDR_IRQ_CLEAR   8'h0C
`define SPC_ADDR_IRQ_ENABLE  8'h10

`define SPC_CTRL_TX_CLK_SEL  0
`define SPC_CTRL_TX_RATE     1
`define SPC_CTRL_TX_HALF     2
`define SPC_CTRL_RX_RATE     3
`define SPC_CTRL_RX_BIST_LO  4
`define SPC_CTRL_RX_BIST_HI  5
`define SPC_CTRL_RECENTER    6
`define SPC_CTRL_RESET       7'h40

`define SPC_IRQ_OVERFLOW     0
`define SPC_IRQ_UNDERFLOW    1
`define SPC_IRQ_RECENTERED   2

`define SPC_BUF_DEPTH        3'h4
`define SPC_BUF_CENTER       3'h2
`define SPC_BIST_REPORT      2'h2
`define SPC_CNT_MAX          8'hFF

`endif

// file: test/spc_pc_sva.sv
// Port-level checker of the parallel clocking block
`timescale 1ns/1ps
module spc_pc_sva
(
    input wire        i_core_clk,
    input wire        i_resetn,
    input wire        i_wb_cyc,
    input wire        i_wb_stb,
    input wire        i_wb_we,
    input wire [7:0]  i_wb_adr,
    input wire [3:0]  i_wb_sel,
    input wire [31:0] i_wb_dat,
    input wire        o_wb_ack,
    input wire [9:0]  o_tx_char,
    input wire        o_tx_char_valid,
    input wire        o_tx_path_error,
    input wire        i_rx_char_valid,
    input wire [9:0]  i_rx_char,
    input wire [2:0]  i_rx_bist_status,
    input wire [9:0]  o_rx_parallel_data,
    input wire        o_rx_clock_out,
    input wire        o_rx_clock_out_n,
    input wire        o_bist_status_bit
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);
    wire       wr = i_wb_cyc && i_wb_stb && !o_wb_ack && i_wb_we && i_wb_sel[0] && (i_wb_adr == 8'h00);
    wire       rc = wr && !i_wb_dat[6];
    reg  [1:0] mode;
    reg        rxh;
    reg        pend;
    // Shadow of the control fields that shape the receive side, and a pending recenter flag
    always @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            mode <= 2'h0;
            rxh  <= 1'b0;
            pend <= 1'b0;
        end
        else
        begin
            if (wr)
            begin
                mode <= i_wb_dat[5:4];
                rxh  <= i_wb_dat[3];
            end
            if (rc)
                pend <= 1'b1;
            else if ($rose(o_tx_path_error))
                pend <= 1'b0;
        end
    end
    AST_ACK_TIME: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("ack late");
    AST_ACK_PULSE: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held");
    AST_CHAR_HOLD: assert property ($changed(o_tx_char) |-> o_tx_char_valid) else $error("char moved");
    AST_ERR_CLEAR: assert property ($fell(o_tx_path_error) |-> pend || rc) else $error("error dropped");
    AST_RX_DATA: assert property (i_rx_char_valid && mode == 2'h0 |=>
        o_rx_parallel_data == $past(i_rx_char)) else $error("rx data");
    AST_RX_BIST: assert property (i_rx_char_valid && mode != 2'h0 |=>
        o_rx_parallel_data == {8'h00, $past(i_rx_bist_status[1:0])}) else $error("rx status");
    AST_BIST_BIT: assert property (i_rx_char_valid |=>
        o_bist_status_bit == ($past(mode) == 2'h2 && $past(i_rx_bist_status[2]))) else $error("status bit");
    AST_RX_FULL: assert property (i_rx_char_valid && !rxh |=> o_rx_clock_out) else $error("rx clock");
    AST_RX_HALF: assert property (i_rx_char_valid && rxh |=> $changed(o_rx_clock_out)) else $error("rx half");
    AST_RX_PAIR: assert property (o_rx_clock_out_n == !o_rx_clock_out) else $error("rx pair");
    cover property ($rose(o_tx_path_error));
    cover property ($fell(o_tx_path_error));
    cover property (i_rx_char_valid && rxh);
endmodule

bind spc_parallel_clocking spc_pc_sva u_sva (.i_core_clk, .i_resetn, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
    .i_wb_sel, .i_wb_dat, .o_wb_ack, .o_tx_char, .o_tx_char_valid, .o_tx_path_error, .i_rx_char_valid, .i_rx_char,
    .i_rx_bist_status, .o_rx_parallel_data, .o_rx_clock_out, .o_rx_clock_out_n, .o_bist_status_bit);

// file: test/spc_pc_partner.sv
// Behavioural co-processor driving the transmit pins
`timescale 1ns/1ps
module spc_pc_partner
(
    input  wire       i_fast,
    output reg        o_ref_clock,
    output reg        o_tx_input_clock,
    output reg  [9:0] o_tx_parallel_data
);
    initial
    begin
        o_ref_clock = 1'b0;
        o_tx_input_clock = 1'b0;
        o_tx_parallel_data = 10'h000;
    end
    always #800 o_ref_clock = ~o_ref_clock;
    // Same rate as the reference, any phase; fast mode forces drift
    initial
    begin
        #300;
        forever #(i_fast ? 600 : 800) o_tx_input_clock = ~o_tx_input_clock;
    end
    // Data moves on the falling edge so it is stable at capture
    always @(negedge o_tx_input_clock)
        o_tx_parallel_data <= o_tx_parallel_data + 10'h001;
endmodule

// file: test/spc_parallel_clocking_tb_top.sv
// Self-checking bench of the parallel clocking block
`timescale 1ns/1ps
module spc_parallel_clocking_tb_top;
    reg         i_core_clk = 0, i_resetn = 0, i_wb_cyc = 0, i_wb_stb = 0, i_wb_we = 0, fast = 0;
    reg  [7:0]  i_wb_adr = 8'h00;
    reg  [3:0]  i_wb_sel = 4'hF;
    reg  [31:0] i_wb_dat = 32'h0, rd;
    reg         i_rx_char_valid = 0;
    reg  [9:0]  i_rx_char = 10'h000, c0;
    reg  [2:0]  i_rx_bist_status = 3'h0;
    wire [31:0] o_wb_dat;
    wire [9:0]  o_tx_char, o_rx_parallel_data, i_tx_parallel_data;
    wire        o_wb_ack, o_irq, o_tx_char_valid, o_tx_clock_out, o_tx_path_error, i_ref_clock;
    wire        o_rx_clock_out, o_rx_clock_out_n, o_bist_status_bit, i_tx_input_clock;
    integer     error_cnt = 0, samples_checked = 0, i, n;
    spc_parallel_clocking dut (.*);
    spc_pc_partner u_peer (.i_fast(fast), .o_ref_clock(i_ref_clock), .o_tx_input_clock(i_tx_input_clock),
        .o_tx_parallel_data(i_tx_parallel_data));
    always #50 i_core_clk = ~i_core_clk;
    task chk(input string nm, input [31:0] got, input [31:0] exp);
    begin
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0s expected %h seen %h", nm, exp, got);
        end
    end
    endtask
    task wb(input w, input [7:0] a, input [31:0] d);
    begin
        @(posedge i_core_clk);
        {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat} <= {2'b11, w, a, d};
        n = 0;
        do begin @(posedge i_core_clk); n++; end while (o_wb_ack !== 1'b1 && n < 50);
        rd = o_wb_dat;
        if (n >= 50) error_cnt++;
        {i_wb_cyc, i_wb_stb} <= 2'b00;
    end
    endtask
    task wv;
    begin
        n = 0;
        do begin @(negedge i_core_clk); n++; end while (o_tx_char_valid !== 1'b1 && n < 100);
    end
    endtask
    task t_tx(input s);
    begin
        wb(1, 8'h00, {31'h0, s});
        repeat (6) wv;
        c0 = o_tx_char;
        repeat (4)
        begin
            wv;
            chk("char", o_tx_char, c0 + 10'h001);
            c0 = o_tx_char;
        end
        chk("no error", o_tx_path_error, 0);
    end
    endtask
    task t_rate(input r);
    begin
        wb(1, 8'h00, {30'h0, r, 1'b0});
        repeat (3) wv;
        @(negedge i_core_clk);
        c0[0] = o_tx_clock_out;
        repeat (64)
        begin
            @(negedge i_core_clk);
            if (o_tx_clock_out === 1'b1 && c0[0] === 1'b0) i++;
            c0[0] = o_tx_clock_out;
        end
    end
    endtask
    task t_err;
    begin
        wb(1, 8'h10, 32'h3);
        fast <= 1;
        repeat (16) wv;
        fast <= 0;
        repeat (4) wv;
        chk("sticky error", o_tx_path_error, 1);
        chk("irq", o_irq, 1);
        wb(0, 8'h08, 0);
        chk("overflow", rd[0], 1);
        wb(1, 8'h10, 0);
        @(negedge i_core_clk);
        chk("masked", o_irq, 0);
        wb(1, 8'h10, 32'h3);
        wb(1, 8'h00, 0);
        repeat (3) wv;
        chk("error clear", o_tx_path_error, 0);
        wb(1, 8'h0C, 32'h7);
        wb(0, 8'h08, 0);
        chk("cleared", rd, 0);
        chk("irq low", o_irq, 0);
    end
    endtask
    task t_rx;
    begin
        for (i = 0; i < 8; i++)
        begin
            wb(1, 8'h00, {26'h0, i[1:0], i[2], 3'h0});
            repeat (2)
            begin
                c0[1] = o_rx_clock_out;
                @(posedge i_core_clk);
                {i_rx_char_valid, i_rx_char, i_rx_bist_status} <= {1'b1, 10'h2A5 ^ i[9:0], 3'h5 ^ i[2:0]};
                @(posedge i_core_clk);
                i_rx_char_valid <= 0;
                @(negedge i_core_clk);
                chk("rx data", o_rx_parallel_data, i[1:0] ? {8'h00, i_rx_bist_status[1:0]} : i_rx_char);
                chk("bist bit", o_bist_status_bit, i[1:0] == 2 && i_rx_bist_status[2]);
                if (i[1:0]) chk("bist low", o_rx_parallel_data[1:0], i_rx_bist_status[1:0]);
                chk("rx pair", o_rx_clock_out_n, !o_rx_clock_out);
                chk("rx clk", o_rx_clock_out, i[2] ? !c0[1] : 1'b1);
                repeat (6) @(posedge i_core_clk);
            end
        end
    end
    endtask
    task test_done;
    begin
        if (error_cnt == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask
    initial
    begin
        #4000000;
        error_cnt++;
        test_done;
    end
    initial
    begin
        repeat (12) @(posedge i_core_clk);
        i_resetn <= 1;
        wb(0, 8'h00, 0);
        chk("ctrl reset", rd, 32'h40);
        wb(0, 8'h3C, 0);
        chk("unmapped", rd, 0);
        t_tx(0);
        t_tx(1);
        i = 0;
        t_rate(0);
        chk("clock x1", i, 4);
        i = 0;
        t_rate(1);
        chk("clock x2", i, 8);
        t_err;
        t_rx;
        test_done;
    end
endmodule
